// ===== verilog/dpr_port_reset.sv
// Reset handshake controller of one downstream facing hub port.
// Assumes the line state input is already sampled and decoded on clk, and
// that the low-speed flag is valid when the reset request pulse arrives.
//
// How it works
// RULE_01: Timers support run, clear and start only.
// RULE_02: Timeouts sit one tick below window limits.
// RULE_03: Request drives SE0 and starts reset timer.
// RULE_04: Low-speed port ends reset only on timeout.
// RULE_05: No valid chirp by timeout gives full-speed.
// RULE_06: Accept Chirp K held continuously for filter time.
// RULE_07: Any interruption of Chirp K clears filter.
// RULE_08: Late chirp detection waits, then full-speed.
// RULE_09: Downstream chirp starts when bus returns SE0.
// RULE_10: Downstream chirp alternates K and J segments.
// RULE_11: Near end, finish segment then drive SE0.
// RULE_12: Device chirps K between 1 and 7 ms.
// RULE_13: Device needs three K to J transitions.
// RULE_14: After closing SE0, enter high-speed enabled.
`default_nettype none

module dpr_port_reset
  import dpr_pkg::*;
#(
  parameter int T_DRST_US   = 10000,
  parameter int T_UCHEND_US = 7000,
  parameter int T_DCHSE0_US = 100
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       port_reset_req,
  input  wire logic       low_speed,
  input  wire logic [1:0] line_state,
  output logic            drive_en,
  output logic [1:0]      drive_sym,
  output logic            resetting,
  output logic            enabled_ls,
  output logic            enabled_fs,
  output logic            enabled_hs
);

  // ******************************************************************
  // Thresholds
  // ******************************************************************
  // Each timeout is taken one tick below its limit because a branch only
  // takes effect on the edge after its compare.
  localparam logic [T0_W-1:0] DRST_AT =
    T0_W'(T_DRST_US * CLK_MHZ - 1); // RULE_02
  localparam logic [T0_W-1:0] UCHEND_AT =
    T0_W'(T_UCHEND_US * CLK_MHZ - 1); // RULE_02
  localparam logic [T0_W-1:0] CHEND_AT =
    T0_W'((T_DRST_US - T_DCHSE0_US) * CLK_MHZ - 1); // RULE_02

  typedef struct packed {
    dpr_state_t state;
    logic       ls;
    logic       drive_en;
    dpr_sym_t   sym;
    logic       resetting;
    logic       en_ls;
    logic       en_fs;
    logic       en_hs;
  } dpr_st_t;

  dpr_st_t st_q;
  dpr_st_t st_d;

  logic             t0_clr;
  logic             seg_clr;
  logic [T0_W-1:0]  t0_cnt;
  logic [SEG_W-1:0] seg_cnt;
  logic             filt_en;
  logic             chirp_ok;
  logic             seg_end;
  logic             t0_drst;

  // ******************************************************************
  // Timers and chirp filter
  // ******************************************************************
  // Timers run every tick and are cleared by the controller, so a start
  // is simply a clear that is released in the next cycle.
  dpr_timer #(
    .W     (T0_W)
  ) u_t0 (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (t0_clr),
    .run   (1'b1),
    .count (t0_cnt)
  );

  dpr_timer #(
    .W     (SEG_W)
  ) u_seg (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (seg_clr),
    .run   (1'b1),
    .count (seg_cnt)
  );

  assign filt_en = (st_q.state == DPR_RESET) && !st_q.ls;

  dpr_filter u_filt (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (filt_en),
    .k_in   (line_state == LINE_K),
    .valid  (chirp_ok)
  );

  assign seg_end = (seg_cnt == SEG_LAST);
  assign t0_drst = (t0_cnt >= DRST_AT);

  // ******************************************************************
  // Handshake control
  // ******************************************************************
  // A request that arrives while a reset is already running is ignored;
  // the running reset finishes on its own timer.
  always_comb
  begin
    st_d    = st_q;
    t0_clr  = 1'b0;
    seg_clr = 1'b0;
    case (st_q.state)
      DPR_IDLE, DPR_LS_EN, DPR_FS_EN, DPR_HS_EN:
      begin
        if (port_reset_req)
        begin
          st_d.state     = DPR_RESET; // RULE_03
          st_d.ls        = low_speed; // RULE_04
          st_d.drive_en  = 1'b1; // RULE_03
          st_d.sym       = DPR_SYM_SE0; // RULE_03
          st_d.resetting = 1'b1;
          st_d.en_ls     = 1'b0;
          st_d.en_fs     = 1'b0;
          st_d.en_hs     = 1'b0;
          t0_clr         = 1'b1; // RULE_03
        end
      end
      DPR_RESET:
      begin
        if (t0_drst)
        begin
          st_d.state     = st_q.ls ? DPR_LS_EN : DPR_FS_EN; // RULE_04 RULE_05
          st_d.drive_en  = 1'b0;
          st_d.resetting = 1'b0;
          st_d.en_ls     = st_q.ls; // RULE_04
          st_d.en_fs     = !st_q.ls; // RULE_05
        end
        else if (!st_q.ls && chirp_ok)
        begin
          st_d.state = DPR_UCH_END; // RULE_06
        end
        else if (!st_q.ls && (t0_cnt >= UCHEND_AT))
        begin
          st_d.state = DPR_WAIT; // RULE_08
        end
      end
      DPR_WAIT:
      begin
        if (t0_drst)
        begin
          st_d.state     = DPR_FS_EN; // RULE_08
          st_d.drive_en  = 1'b0;
          st_d.resetting = 1'b0;
          st_d.en_fs     = 1'b1; // RULE_08
        end
      end
      DPR_UCH_END:
      begin
        // The device ends its chirp in time on its own side.
        if (t0_drst)
        begin
          st_d.state     = DPR_FS_EN; // RULE_12
          st_d.drive_en  = 1'b0;
          st_d.resetting = 1'b0;
          st_d.en_fs     = 1'b1;
        end
        else if (line_state == LINE_SE0)
        begin
          st_d.state = DPR_DCH; // RULE_09
          st_d.sym   = DPR_SYM_K; // RULE_09
          seg_clr    = 1'b1; // RULE_10
        end
      end
      DPR_DCH:
      begin
        if (seg_end)
        begin
          seg_clr = 1'b1; // RULE_10
          if (t0_cnt >= CHEND_AT)
          begin
            st_d.state = DPR_DSE0; // RULE_11
            st_d.sym   = DPR_SYM_SE0; // RULE_11
          end
          else
          begin
            st_d.sym = (st_q.sym == DPR_SYM_K) ? DPR_SYM_J
                                               : DPR_SYM_K; // RULE_10
          end
        end
      end
      DPR_DSE0:
      begin
        if (t0_drst)
        begin
          st_d.state     = DPR_HS_EN; // RULE_14
          st_d.drive_en  = 1'b0;
          st_d.resetting = 1'b0;
          st_d.en_hs     = 1'b1; // RULE_14
        end
      end
      default:
      begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign drive_en   = st_q.drive_en;
  assign drive_sym  = st_q.sym;
  assign resetting  = st_q.resetting;
  assign enabled_ls = st_q.en_ls;
  assign enabled_fs = st_q.en_fs;
  assign enabled_hs = st_q.en_hs;

  // ******************************************************************
  // Checks
  // ******************************************************************
  AST_REQ_SE0: assert property (@(posedge clk) disable iff (!rst_n)
    (port_reset_req && !st_q.resetting) |=>
      drive_en && (drive_sym == DPR_SYM_SE0) && (t0_cnt == '0)) // RULE_03
    else $error("reset request did not drive SE0 and start the timer");

  AST_LS_END: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_RESET && st_q.ls && t0_drst) |=>
      enabled_ls && !drive_en && !enabled_fs) // RULE_04
    else $error("low-speed reset did not end in low-speed enabled");

  AST_LS_NO_CHIRP: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_RESET && st_q.ls) |=>
      (st_q.state != DPR_UCH_END) && (st_q.state != DPR_WAIT)) // RULE_04
    else $error("low-speed port took part in the chirp handshake");

  AST_FS_END: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_RESET && !st_q.ls && t0_drst) |=>
      enabled_fs && !enabled_hs) // RULE_05
    else $error("reset without chirp did not end in full-speed");

  AST_LATE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_RESET && !st_q.ls && !chirp_ok && !t0_drst &&
     t0_cnt >= UCHEND_AT) |=> (st_q.state == DPR_WAIT)) // RULE_08
    else $error("late chirp detection did not enter the wait state");

  AST_WAIT_FS: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_WAIT && t0_drst) |=> enabled_fs) // RULE_08
    else $error("wait state did not end in full-speed");

  AST_DCH_START: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_UCH_END && !t0_drst && line_state == LINE_SE0) |=>
      drive_en && (drive_sym == DPR_SYM_K) && (seg_cnt == '0)) // RULE_09
    else $error("downstream chirp did not start on SE0");

  AST_SEG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_DCH && !seg_end) |=> $stable(drive_sym)) // RULE_10
    else $error("chirp segment changed before its time");

  AST_SEG_FLIP: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_DCH && seg_end && t0_cnt < CHEND_AT) |=>
      (drive_sym != $past(drive_sym)) && (drive_sym != DPR_SYM_SE0)) // RULE_10
    else $error("chirp segment did not alternate");

  AST_CHIRP_TAIL: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_DCH && seg_end && t0_cnt >= CHEND_AT) |=>
      (drive_sym == DPR_SYM_SE0) && drive_en) // RULE_11
    else $error("chirp did not close with SE0");

  AST_HS_END: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_DSE0 && t0_drst) |=>
      enabled_hs && !drive_en && !resetting) // RULE_14
    else $error("closing SE0 did not end in high-speed enabled");

  COV_LS: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(enabled_ls));

  COV_FS_WAIT: cover property (@(posedge clk) disable iff (!rst_n)
    (st_q.state == DPR_WAIT) ##1 $rose(enabled_fs));

  COV_HS: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(enabled_hs));

endmodule : dpr_port_reset

`default_nettype wire

// ===== verilog/dpr_pkg.sv
// Constants, encodings and state types of the downstream port reset handshake.
// Assumes a single 10 MHz clock shared by every module of the block.
`default_nettype none

package dpr_pkg;

  // ******************************************************************
  // Clock and timing
  // ******************************************************************
  localparam int CLK_MHZ     = 10;
  localparam int T_FILT_NS   = 2500;
  // A least time: rounded up to whole cycles.
  localparam int FILT_CYC    = (T_FILT_NS * CLK_MHZ + 999) / 1000;
  // Chirp segment target, well inside its 40 to 60 us window.
  localparam int T_DCHBIT_US = 50;
  localparam int SEG_CYC     = T_DCHBIT_US * CLK_MHZ;

  localparam int T0_W        = 20;
  localparam int SEG_W       = 10;
  localparam int FILT_W      = 5;

  localparam logic [SEG_W-1:0]  SEG_LAST  = SEG_W'(SEG_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);

  // ******************************************************************
  // Line and drive encodings
  // ******************************************************************
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J   = 2'h1;
  localparam logic [1:0] LINE_K   = 2'h2;

  typedef enum logic [1:0] {
    DPR_SYM_SE0 = 2'h0,
    DPR_SYM_J   = 2'h1,
    DPR_SYM_K   = 2'h2
  } dpr_sym_t;

  // Gray codes along the usual path of a reset.
  typedef enum logic [3:0] {
    DPR_IDLE    = 4'h0,
    DPR_RESET   = 4'h1,
    DPR_UCH_END = 4'h3,
    DPR_DCH     = 4'h2,
    DPR_DSE0    = 4'h6,
    DPR_HS_EN   = 4'h7,
    DPR_WAIT    = 4'h5,
    DPR_FS_EN   = 4'h4,
    DPR_LS_EN   = 4'hc
  } dpr_state_t;

endpackage : dpr_pkg

`default_nettype wire

// ===== verilog/dpr_timer.sv
// Generic up-counting timer with clear and run controls.
// Assumes the owner holds clear and run as levels in the same cycle.
`default_nettype none

module dpr_timer
  import dpr_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         run,
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } dpr_tmr_st_t;

  dpr_tmr_st_t st_q;
  dpr_tmr_st_t st_d;

  // ******************************************************************
  // Count
  // ******************************************************************
  // Start is clear in one cycle followed by run; the count saturates so
  // that a long wait can never wrap back below a threshold.
  always_comb
  begin
    st_d = st_q;
    if (clear)
    begin
      st_d.cnt = '0; // RULE_01
    end
    else if (run && (st_q.cnt != {W{1'b1}}))
    begin
      st_d.cnt = st_q.cnt + W'(1); // RULE_01
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign count = st_q.cnt;

  AST_TMR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> (count == '0)) // RULE_01
    else $error("timer did not clear");

endmodule : dpr_timer

`default_nettype wire

// ===== verilog/dpr_filter.sv
// Continuity filter that accepts a Chirp K held for the filter time.
// Assumes line samples are synchronous to clk, one sample per cycle.
`default_nettype none

module dpr_filter
  import dpr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic k_in,
  output logic      valid
);

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic              valid;
  } dpr_flt_st_t;

  dpr_flt_st_t st_q;
  dpr_flt_st_t st_d;

  // ******************************************************************
  // Filter timer
  // ******************************************************************
  // One clock is far longer than 16 high-speed bit times, so any sampled
  // break in the Chirp K clears the count; this is the permitted stricter
  // choice and can only delay acceptance.
  always_comb
  begin
    st_d = st_q;
    if (!enable)
    begin
      st_d = '0;
    end
    else if (!k_in)
    begin
      st_d.cnt = '0; // RULE_07
    end
    else if (st_q.cnt == FILT_LAST)
    begin
      st_d.valid = 1'b1; // RULE_06
    end
    else
    begin
      st_d.cnt = st_q.cnt + FILT_W'(1); // RULE_06
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign valid = st_q.valid;

  AST_FLT_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
    (enable && !k_in) |=> (st_q.cnt == '0)) // RULE_07
    else $error("filter count survived a break in Chirp K");

  AST_FLT_ACCEPT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(valid) |-> ($past(st_q.cnt) == FILT_LAST) && $past(k_in)) // RULE_06
    else $error("chirp accepted before the filter time");

endmodule : dpr_filter

`default_nettype wire

// ===== tb/dpr_dev_model.sv
// Behavioural model of the device attached to the downstream port.
// Assumes the port's drive outputs are registered on clk.
`default_nettype none

module dpr_dev_model
  import dpr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode,
  input  wire logic       drive_en,
  input  wire logic [1:0] drive_sym,
  output logic [1:0]      line_state,
  output logic [3:0]      kj_count
);
  timeunit 1ns;
  timeprecision 100ps;

  // Mode 0 never chirps, 1 chirps promptly, 2 chirps too late and
  // 3 chirps with a short break every 20 cycles, so it never filters.
  int         cyc_q;
  int         hold_q;
  int         run_len;
  int         start;
  logic       chirping;
  logic       k_armed_q;
  logic [1:0] last_q;

  assign start    = (mode == 2'h2) ? 2600 : 10;
  assign chirping = (mode != 2'h0) && (cyc_q >= start)
                    && (cyc_q < start + 100);
  // Length of the run of equal samples that the current one extends.
  assign run_len  = (line_state == last_q) ? hold_q + 1 : 1;

  always_comb
  begin
    if (chirping)
      line_state = (mode == 2'h3 && cyc_q % 20 == 0) ? LINE_SE0 : LINE_K;
    else if (drive_en)
      line_state = drive_sym;
    else
      line_state = LINE_J;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !drive_en)
    begin
      cyc_q     <= 0;
      hold_q    <= 0;
      last_q    <= LINE_SE0;
      k_armed_q <= 1'b0;
      kj_count  <= 4'h0;
    end
    else
    begin
      cyc_q  <= cyc_q + 1;
      last_q <= line_state;
      hold_q <= run_len;
      // A K held long enough arms the count; a J held long enough after
      // it completes one transition, so short glitches never count.
      if (line_state == LINE_K && run_len == FILT_CYC)
        k_armed_q <= 1'b1;
      else if (line_state == LINE_J && run_len == FILT_CYC && k_armed_q)
      begin
        k_armed_q <= 1'b0;
        kj_count  <= kj_count + 4'h1;
      end
      else if (line_state != LINE_K && line_state != LINE_J)
        k_armed_q <= 1'b0;
    end
  end
endmodule : dpr_dev_model

`default_nettype wire

// ===== tb/downstream_port_reset_handshake_tb.sv
// Self-checking bench of the downstream port reset handshake.
// Assumes shortened reset timings so that one reset takes 4000 cycles.
`default_nettype none

module downstream_port_reset_handshake_tb
  import dpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int N     = 400 * 10 - 1;
  localparam int LIMIT = 80000;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       port_reset_req = 1'b0;
  logic       low_speed = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] line_state;
  logic       drive_en;
  logic [1:0] drive_sym;
  logic       resetting;
  logic       enabled_ls;
  logic       enabled_fs;
  logic       enabled_hs;
  logic [3:0] kj_count;
  logic [1:0] prev_sym = 2'h0;
  int         seg_len = 0;
  int         cycles = 0;
  int         miscompares = 0;
  int         compares = 0;

  always #50 clk = ~clk;

  dpr_port_reset #(
    .T_DRST_US   (400),
    .T_UCHEND_US (250),
    .T_DCHSE0_US (60)
  ) dut (
    .clk            (clk),
    .rst_n          (rst_n),
    .port_reset_req (port_reset_req),
    .low_speed      (low_speed),
    .line_state     (line_state),
    .drive_en       (drive_en),
    .drive_sym      (drive_sym),
    .resetting      (resetting),
    .enabled_ls     (enabled_ls),
    .enabled_fs     (enabled_fs),
    .enabled_hs     (enabled_hs)
  );

  dpr_dev_model dev (
    .clk        (clk),
    .rst_n      (rst_n),
    .mode       (mode),
    .drive_en   (drive_en),
    .drive_sym  (drive_sym),
    .line_state (line_state),
    .kj_count   (kj_count)
  );

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Speed flags as {hs, fs, ls}; only a clean prompt chirp earns high speed.
  function automatic logic [2:0] expect_speed(input logic [1:0] m,
                                              input logic ls);
    if (ls)
      return 3'h1;
    return (m == 2'h1) ? 3'h4 : 3'h2;
  endfunction : expect_speed

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic run_one(input logic [1:0] m, input logic ls);
    int dur;
    mode           = m;
    low_speed      = ls;
    port_reset_req = 1'b1;
    step();
    port_reset_req = 1'b0;
    low_speed      = ~ls;
    check({resetting, drive_en, drive_sym}, {2'h3, LINE_SE0});
    check({enabled_hs, enabled_fs, enabled_ls}, 3'h0);
    dur = 1;
    repeat (499) step();
    // A second request in mid-reset must not restart the timing.
    port_reset_req = 1'b1;
    step();
    port_reset_req = 1'b0;
    dur = 501;
    while (resetting === 1'b1 && dur < N + 100)
    begin
      step();
      dur++;
    end
    check(dur >= N && dur <= N + 3, 1);
    check(drive_en, 1'b0);
    check({enabled_hs, enabled_fs, enabled_ls}, expect_speed(m, ls));
    if (expect_speed(m, ls) == 3'h4)
      check(kj_count >= 4'h3, 1);
    else
      check(kj_count, 4'h0);
    repeat (5) step();
  endtask : run_one

  // A reset cut into a handshake must leave every output idle. It lands
  // while the filter is still counting, so no chirp segment is cut short.
  task automatic cut_by_reset();
    mode           = 2'h1;
    low_speed      = 1'b0;
    port_reset_req = 1'b1;
    step();
    port_reset_req = 1'b0;
    repeat (30) step();
    rst_n = 1'b0;
    repeat (2) step();
    check({resetting, drive_en, drive_sym}, 4'h0);
    check({enabled_hs, enabled_fs, enabled_ls}, 3'h0);
    rst_n = 1'b1;
  endtask : cut_by_reset

  // Every finished chirp segment must last exactly one segment time.
  always @(posedge clk)
  begin
    if (drive_en === 1'b1 && drive_sym != LINE_SE0 && drive_sym == prev_sym)
      seg_len <= seg_len + 1;
    else
    begin
      if (prev_sym != LINE_SE0)
        check(seg_len, SEG_CYC);
      if (drive_en === 1'b1 && drive_sym != LINE_SE0)
        check(drive_sym, (prev_sym == LINE_K) ? LINE_J : LINE_K);
      seg_len <= 1;
    end
    prev_sym <= (drive_en === 1'b1) ? drive_sym : LINE_SE0;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    logic [1:0] m;
    void'($urandom(32'h1156));
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Hand-written corners: every device kind and a chirping low-speed one.
    for (int i = 0; i < 4; i++)
      run_one(2'(i), 1'b0);
    run_one(2'h1, 1'b1);
    cut_by_reset();
    for (int i = 0; i < 6; i++)
    begin
      m = 2'($urandom % 4);
      run_one(m, 1'($urandom % 4 == 0));
    end
    wrap_up();
  end
endmodule : downstream_port_reset_handshake_tb

`default_nettype wire
